//--- hdl/csr_regs.sv
// Core special-function register set: stack, data pointer, serial buffer, status word, timers
`timescale 1ns/1ps
// Function
// (RL1) The stack pointer is an 8-bit register that may point anywhere in on-chip RAM.
// (RL2) A push or call first increments the stack pointer and then stores at the new address.
// (RL3) Reset loads the stack pointer with 07H so the first stored byte lands at 08H.
// (RL4) The data pointer is a high and a low byte, usable as one 16-bit value or two bytes.
// (RL5) Writing the serial buffer loads a transmit holding register and starts transmission.
// (RL6) Reading the serial buffer returns a separate receive register.
// (RL7) Status bit 0 tracks accumulator parity every cycle: set when the count of ones is odd.
// (RL8) Status bits 4 and 3 pick one of four register banks, 11 mapping to RAM 18H-1FH.
// (RL9) Status bits 7, 6 and 2 hold carry, auxiliary carry and overflow.
// (RL10) Status bits 5 and 1 are software flags that hardware never alters.
// (RL11) Each of three timers keeps its count in a readable, writable high/low byte pair.
// (RL12) Timer 2 auto-reload takes its value from the capture pair.
// (RL13) In capture mode an external trigger transition copies timer 2 into the capture pair.
// (RL14) As a 16-bit value the data pointer holds the high byte in 15:8 and the low in 7:0.
module csr_regs
   import csr_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic [CSR_AW-1:0]    reg_addr,
   input  wire logic [CSR_DW-1:0]    reg_wdata,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   output logic      [CSR_DW-1:0]    reg_rdata,
   input  wire logic                 stack_push,
   input  wire logic                 stack_pop,
   output logic      [7:0]           stack_store_addr,
   output logic                      stack_store_strobe,
   input  wire logic                 data_pointer_load,
   input  wire logic [15:0]          data_pointer_value,
   input  wire logic                 data_pointer_incr,
   output logic      [15:0]          data_pointer_pair,
   input  wire logic                 alu_flags_write,
   input  wire logic                 alu_carry,
   input  wire logic                 alu_aux_carry,
   input  wire logic                 alu_overflow,
   input  wire logic                 acc_write,
   input  wire logic [7:0]           acc_value,
   output logic      [7:0]           bank_base_addr,
   output logic      [7:0]           tx_holding,
   output logic                      tx_start,
   input  wire logic                 rx_valid,
   input  wire logic [7:0]           rx_data,
   input  wire logic                 timer0_tick,
   input  wire logic                 timer1_tick,
   input  wire logic                 timer2_tick,
   input  wire logic                 timer2_external_trigger,
   output logic                      timer0_overflow,
   output logic                      timer1_overflow,
   output logic                      timer2_overflow
);
   import csr_pkg::*;

   logic [7:0]  stack_top_pointer;
   logic [7:0]  data_pointer_high_byte;
   logic [7:0]  data_pointer_low_byte;
   logic [7:0]  processor_status_flags;
   logic [7:0]  accumulator;
   logic [7:0]  rx_buffer;
   logic [7:0]  timer2_capture_high;
   logic [7:0]  timer2_capture_low;
   logic [7:0]  timer2_control;
   logic        trigger_prev;

   wire logic [15:0] timer_count [3];
   wire logic [2:0]  timer_ovf;
   wire logic [2:0]  timer_tick;
   wire logic [2:0]  timer_wr_low;
   wire logic [2:0]  timer_wr_high;

   // Decode
   wire logic wr_stack  = reg_write && (reg_addr == CSR_OFF_STACK);
   wire logic wr_dpl    = reg_write && (reg_addr == CSR_OFF_DPL);
   wire logic wr_dph    = reg_write && (reg_addr == CSR_OFF_DPH);
   wire logic wr_serial = reg_write && (reg_addr == CSR_OFF_SERIAL);
   wire logic wr_status = reg_write && (reg_addr == CSR_OFF_STATUS);
   wire logic wr_acc    = reg_write && (reg_addr == CSR_OFF_ACC);
   wire logic wr_capl   = reg_write && (reg_addr == CSR_OFF_CAPL);
   wire logic wr_caph   = reg_write && (reg_addr == CSR_OFF_CAPH);
   wire logic wr_t2ctl  = reg_write && (reg_addr == CSR_OFF_T2CTL);

   wire csr_t2_mode_t t2_mode = timer2_control[CSR_BIT_T2_CAPEN] ? CSR_T2_CAPTURE : CSR_T2_RELOAD;
   wire logic t2_run          = timer2_control[CSR_BIT_T2_RUN];
   wire logic trigger_edge    = trigger_prev && !timer2_external_trigger;
   wire logic capture_fire    = (t2_mode == CSR_T2_CAPTURE) && trigger_edge; // RL13

   // Stack pointer: pre-increment on store, address of store is the new value
   wire logic [7:0] stack_inc = stack_top_pointer + 8'h01;
   wire logic [7:0] next_stack_top_pointer = wr_stack   ? reg_wdata :
                                             stack_push ? stack_inc :             // RL2
                                             stack_pop  ? stack_top_pointer - 8'h01 :
                                             stack_top_pointer;
   assign stack_store_addr   = stack_inc;                                          // RL2
   assign stack_store_strobe = stack_push;

   // Data pointer as a 16-bit value
   assign data_pointer_pair = {data_pointer_high_byte, data_pointer_low_byte};     // RL14
   wire logic [15:0] data_pointer_pair_inc = data_pointer_pair + 16'h0001;
   wire logic [15:0] next_data_pointer_pair = data_pointer_load ? data_pointer_value :
                                 data_pointer_incr ? data_pointer_pair_inc : data_pointer_pair; // RL4

   // Status word: parity from the accumulator, banks from bits 4:3
   wire logic [7:0] next_accumulator = wr_acc ? reg_wdata : (acc_write ? acc_value : accumulator);
   wire logic       parity_odd       = ^next_accumulator;                          // RL7
   wire logic [7:0] status_sw        = wr_status ? reg_wdata : processor_status_flags;
   wire logic [7:0] next_processor_status_flags;
   assign next_processor_status_flags[CSR_BIT_CARRY]    = alu_flags_write ? alu_carry : status_sw[CSR_BIT_CARRY];
   assign next_processor_status_flags[CSR_BIT_AUX]      = alu_flags_write ? alu_aux_carry : status_sw[CSR_BIT_AUX];
   assign next_processor_status_flags[CSR_BIT_OVERFLOW] = alu_flags_write ? alu_overflow : status_sw[CSR_BIT_OVERFLOW];
   assign next_processor_status_flags[CSR_BIT_FLAG_A]   = status_sw[CSR_BIT_FLAG_A];   // RL10
   assign next_processor_status_flags[CSR_BIT_FLAG_B]   = status_sw[CSR_BIT_FLAG_B];   // RL10
   assign next_processor_status_flags[CSR_BIT_BANK_HI]  = status_sw[CSR_BIT_BANK_HI];  // RL8
   assign next_processor_status_flags[CSR_BIT_BANK_LO]  = status_sw[CSR_BIT_BANK_LO];  // RL8
   assign next_processor_status_flags[CSR_BIT_PARITY]   = parity_odd;                  // RL7

   wire logic [1:0] bank_sel = {processor_status_flags[CSR_BIT_BANK_HI], processor_status_flags[CSR_BIT_BANK_LO]};
   assign bank_base_addr = 8'(bank_sel * CSR_BANK_STRIDE);                         // RL8

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stack_top_pointer <= CSR_RST_STACK;                                       // RL3
      end else begin
         stack_top_pointer <= next_stack_top_pointer;                              // RL1
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         data_pointer_high_byte <= CSR_RST_ZERO;
         data_pointer_low_byte  <= CSR_RST_ZERO;
      end else begin
         data_pointer_high_byte <= wr_dph ? reg_wdata : next_data_pointer_pair[15:8];           // RL4
         data_pointer_low_byte  <= wr_dpl ? reg_wdata : next_data_pointer_pair[7:0];            // RL4
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         accumulator            <= CSR_RST_ZERO;
         processor_status_flags <= CSR_RST_ZERO;
      end else begin
         accumulator            <= next_accumulator;
         processor_status_flags <= next_processor_status_flags;                    // RL9
      end
   end

   // Serial buffer: separate transmit holding and receive registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_holding <= CSR_RST_ZERO;
         tx_start   <= 1'b0;
         rx_buffer  <= CSR_RST_ZERO;
      end else begin
         tx_start <= wr_serial;                                                    // RL5
         if (wr_serial) tx_holding <= reg_wdata;                                   // RL5
         if (rx_valid) rx_buffer <= rx_data;                                       // RL6
      end
   end

   // Timer 2 control and capture pair; the capture edge wins over a software write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         timer2_control      <= CSR_RST_ZERO;
         timer2_capture_high <= CSR_RST_ZERO;
         timer2_capture_low  <= CSR_RST_ZERO;
         trigger_prev        <= 1'b0;
      end else begin
         trigger_prev <= timer2_external_trigger;
         if (wr_t2ctl) timer2_control <= reg_wdata;
         if (capture_fire) begin
            timer2_capture_high <= timer_count[2][15:8];                           // RL13
            timer2_capture_low  <= timer_count[2][7:0];                            // RL13
         end else begin
            if (wr_caph) timer2_capture_high <= reg_wdata;
            if (wr_capl) timer2_capture_low  <= reg_wdata;
         end
      end
   end

   // Timer count pairs
   assign timer_tick    = {timer2_tick && t2_run, timer1_tick, timer0_tick};
   assign timer_wr_low  = {reg_write && (reg_addr == CSR_OFF_T2L), reg_write && (reg_addr == CSR_OFF_T1L),
                           reg_write && (reg_addr == CSR_OFF_T0L)};
   assign timer_wr_high = {reg_write && (reg_addr == CSR_OFF_T2H), reg_write && (reg_addr == CSR_OFF_T1H),
                           reg_write && (reg_addr == CSR_OFF_T0H)};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_timer
         csr_timer_pair u_timer (                                                  // RL11
            .clk          (clk),
            .reset        (reset),
            .count_en     (timer_tick[gi]),
            .write_low    (timer_wr_low[gi]),
            .write_high   (timer_wr_high[gi]),
            .write_data   (reg_wdata),
            .reload_en    ((gi == 2) && (t2_mode == CSR_T2_RELOAD)),
            .reload_value ({timer2_capture_high, timer2_capture_low}),             // RL12
            .count        (timer_count[gi]),
            .overflow     (timer_ovf[gi])
         );
      end
   endgenerate

   assign timer0_overflow = timer_ovf[0];
   assign timer1_overflow = timer_ovf[1];
   assign timer2_overflow = timer_ovf[2];

   // Read mux
   logic [7:0] read_mux;
   always_comb begin
      case (reg_addr)
         CSR_OFF_STACK:  read_mux = stack_top_pointer;
         CSR_OFF_DPL:    read_mux = data_pointer_low_byte;
         CSR_OFF_DPH:    read_mux = data_pointer_high_byte;
         CSR_OFF_SERIAL: read_mux = rx_buffer;                                     // RL6
         CSR_OFF_STATUS: read_mux = processor_status_flags;
         CSR_OFF_ACC:    read_mux = accumulator;
         CSR_OFF_T2CTL:  read_mux = timer2_control;
         CSR_OFF_CAPL:   read_mux = timer2_capture_low;
         CSR_OFF_CAPH:   read_mux = timer2_capture_high;
         CSR_OFF_T0L:    read_mux = timer_count[0][7:0];
         CSR_OFF_T0H:    read_mux = timer_count[0][15:8];
         CSR_OFF_T1L:    read_mux = timer_count[1][7:0];
         CSR_OFF_T1H:    read_mux = timer_count[1][15:8];
         CSR_OFF_T2L:    read_mux = timer_count[2][7:0];
         CSR_OFF_T2H:    read_mux = timer_count[2][15:8];
         default:        read_mux = CSR_READ_UNMAPPED;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= CSR_RST_ZERO;
      end else begin
         reg_rdata <= reg_read ? read_mux : CSR_RST_ZERO;
      end
   end
endmodule

//--- hdl/csr_pkg.sv
// Package: offsets, field positions, reset values and enums for the core special registers
package csr_pkg;
   localparam int          CSR_AW            = 8;
   localparam int          CSR_DW            = 8;
   // Register offsets (locally chosen map)
   localparam logic [7:0]  CSR_OFF_STACK     = 8'h81;
   localparam logic [7:0]  CSR_OFF_DPL       = 8'h82;
   localparam logic [7:0]  CSR_OFF_DPH       = 8'h83;
   localparam logic [7:0]  CSR_OFF_T0L       = 8'h8A;
   localparam logic [7:0]  CSR_OFF_T1L       = 8'h8B;
   localparam logic [7:0]  CSR_OFF_T0H       = 8'h8C;
   localparam logic [7:0]  CSR_OFF_T1H       = 8'h8D;
   localparam logic [7:0]  CSR_OFF_SERIAL    = 8'h99;
   localparam logic [7:0]  CSR_OFF_T2CTL     = 8'hC8;
   localparam logic [7:0]  CSR_OFF_CAPL      = 8'hCA;
   localparam logic [7:0]  CSR_OFF_CAPH      = 8'hCB;
   localparam logic [7:0]  CSR_OFF_T2L       = 8'hCC;
   localparam logic [7:0]  CSR_OFF_T2H       = 8'hCD;
   localparam logic [7:0]  CSR_OFF_STATUS    = 8'hD0;
   localparam logic [7:0]  CSR_OFF_ACC       = 8'hE0;
   // Status word field positions
   localparam int          CSR_BIT_CARRY     = 7;
   localparam int          CSR_BIT_AUX       = 6;
   localparam int          CSR_BIT_FLAG_A    = 5;
   localparam int          CSR_BIT_BANK_HI   = 4;
   localparam int          CSR_BIT_BANK_LO   = 3;
   localparam int          CSR_BIT_OVERFLOW  = 2;
   localparam int          CSR_BIT_FLAG_B    = 1;
   localparam int          CSR_BIT_PARITY    = 0;
   // Timer 2 control field positions
   localparam int          CSR_BIT_T2_RUN    = 2;
   localparam int          CSR_BIT_T2_CAPEN  = 0;
   // Reset values, bank stride and unmapped read value
   localparam logic [7:0]  CSR_RST_STACK     = 8'h07;
   localparam logic [7:0]  CSR_RST_ZERO      = 8'h00;
   localparam logic [7:0]  CSR_BANK_STRIDE   = 8'h08;
   localparam logic [7:0]  CSR_READ_UNMAPPED = 8'h00;
   typedef enum logic {CSR_T2_RELOAD, CSR_T2_CAPTURE} csr_t2_mode_t;
endpackage

//--- hdl/csr_timer_pair.sv
// One 16-bit timer count pair with byte write access and optional reload
`timescale 1ns/1ps
module csr_timer_pair
   import csr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        count_en,
   input  wire logic        write_low,
   input  wire logic        write_high,
   input  wire logic [7:0]  write_data,
   input  wire logic        reload_en,
   input  wire logic [15:0] reload_value,
   output logic      [15:0] count,
   output logic             overflow
);
   import csr_pkg::*;

   wire logic [15:0] next_count;
   wire logic        at_top;

   assign at_top     = (count == 16'hFFFF);
   assign overflow   = count_en && at_top;
   assign next_count = (at_top && reload_en) ? reload_value : count + 16'h0001;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= 16'h0000;
      end else if (write_low || write_high) begin
         if (write_low) count[7:0] <= write_data;
         if (write_high) count[15:8] <= write_data;
      end else if (count_en) begin
         count <= next_count;
      end
   end
endmodule

//--- tb/csr_regs_checker.sv
// Checker: concurrent assertions on the special register set ports
`timescale 1ns/1ps
module csr_regs_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   input wire logic        stack_push,
   input wire logic        stack_pop,
   input wire logic [7:0]  stack_store_addr,
   input wire logic        stack_store_strobe,
   input wire logic        data_pointer_load,
   input wire logic [15:0] data_pointer_value,
   input wire logic        data_pointer_incr,
   input wire logic [15:0] data_pointer_pair,
   input wire logic [7:0]  bank_base_addr,
   input wire logic [7:0]  tx_holding,
   input wire logic        tx_start,
   input wire logic        timer0_tick,
   input wire logic        timer0_overflow
);
   import csr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire stack_wr = reg_write && reg_addr == CSR_OFF_STACK;
   wire ser_wr   = reg_write && reg_addr == CSR_OFF_SERIAL;
   wire stat_wr  = reg_write && reg_addr == CSR_OFF_STATUS;
   wire dp_wr    = reg_write && (reg_addr == CSR_OFF_DPL || reg_addr == CSR_OFF_DPH);
   sequence s_clean_push; stack_push && !stack_pop && !stack_wr; endsequence
   sequence s_ser_write; ser_wr ##1 1'b1; endsequence
   property p_strobe; stack_store_strobe == stack_push; endproperty
   property p_push_step; s_clean_push ##1 stack_push |-> stack_store_addr == $past(stack_store_addr) + 8'h01; endproperty
   property p_tx_load; s_ser_write |-> tx_start && tx_holding == $past(reg_wdata); endproperty
   property p_tx_quiet; !ser_wr |=> !tx_start; endproperty
   property p_rdata_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
   property p_dp_load; data_pointer_load && !dp_wr |=> data_pointer_pair == $past(data_pointer_value); endproperty
   property p_dp_incr; data_pointer_incr && !data_pointer_load && !dp_wr |=> data_pointer_pair == $past(data_pointer_pair) + 16'h0001; endproperty
   property p_bank; stat_wr |=> bank_base_addr == {3'b000, $past(reg_wdata[4:3]), 3'b000}; endproperty
   property p_t0_ovf; timer0_overflow |-> timer0_tick; endproperty
   property p_sp_hold; !stack_push && !stack_pop && !stack_wr |=> $stable(stack_store_addr); endproperty
   a_strobe:     assert property (p_strobe) else $error("store strobe differs from push");
   a_push_step:  assert property (p_push_step) else $error("push address did not step by one");
   a_tx_load:    assert property (p_tx_load) else $error("serial write did not start transmit");
   a_tx_quiet:   assert property (p_tx_quiet) else $error("transmit start without serial write");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   a_dp_load:    assert property (p_dp_load) else $error("pointer load wrong");
   a_dp_incr:    assert property (p_dp_incr) else $error("pointer increment wrong");
   a_bank:       assert property (p_bank) else $error("bank base wrong");
   a_t0_ovf:     assert property (p_t0_ovf) else $error("timer overflow without tick");
   a_sp_hold:    assert property (p_sp_hold) else $error("stack pointer moved without push, pop or write");
endmodule
bind csr_regs csr_regs_checker chk_i (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .stack_push, .stack_pop, .stack_store_addr, .stack_store_strobe, .data_pointer_load, .data_pointer_value,
   .data_pointer_incr, .data_pointer_pair, .bank_base_addr, .tx_holding, .tx_start, .timer0_tick, .timer0_overflow);

//--- tb/mcu_core_special_registers_bench.sv
// Testbench: scoreboard model of the special register set driven over the register port
`timescale 1ns/1ps
module mcu_core_special_registers_bench;
   import csr_pkg::*;
   logic        clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   logic        alu_carry = 1'b0, alu_aux_carry = 1'b0, alu_overflow = 1'b0, timer1_tick = 1'b0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, acc_value = 8'h00, rx_data = 8'h00;
   logic [15:0] data_pointer_value = 16'h0000;
   logic [9:0]  ctl = 10'h000;
   wire  logic  stack_push, stack_pop, data_pointer_load, data_pointer_incr, alu_flags_write;
   wire  logic  acc_write, rx_valid, timer0_tick, timer2_tick, timer2_external_trigger;
   logic [7:0]  reg_rdata, stack_store_addr, bank_base_addr, tx_holding;
   logic [15:0] data_pointer_pair, snap, w;
   logic        stack_store_strobe, tx_start, timer0_overflow, timer1_overflow, timer2_overflow;
   int          n_errors = 0, n_tests = 0, seed = 45, i;
   logic [7:0]  m_sp, m_flags, v;
   logic [15:0] m_dp;
   logic [7:0]  offs [6] = '{CSR_OFF_T0L, CSR_OFF_T0H, CSR_OFF_T1L, CSR_OFF_T1H, CSR_OFF_T2L, CSR_OFF_T2H};
   assign {timer2_external_trigger, timer2_tick, timer0_tick, rx_valid, acc_write, alu_flags_write,
           data_pointer_incr, data_pointer_load, stack_pop, stack_push} = ctl;
   csr_regs uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .stack_push,
      .stack_pop, .stack_store_addr, .stack_store_strobe, .data_pointer_load, .data_pointer_value,
      .data_pointer_incr, .data_pointer_pair, .alu_flags_write, .alu_carry, .alu_aux_carry, .alu_overflow,
      .acc_write, .acc_value, .bank_base_addr, .tx_holding, .tx_start, .rx_valid, .rx_data, .timer0_tick,
      .timer1_tick, .timer2_tick, .timer2_external_trigger, .timer0_overflow, .timer1_overflow, .timer2_overflow);
   always #12.5 clk = ~clk;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk(what, {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   // Raises one control pulse for a cycle and snapshots the store address and the timer 0 and timer 2 overflow outputs meanwhile
   task automatic pulse(input int k);
      @(posedge clk);
      ctl[k] <= 1'b1;
      #1 snap = {6'h00, timer2_overflow, timer0_overflow, stack_store_addr};
      @(posedge clk);
      ctl[k] <= 1'b0;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #50000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      m_sp = CSR_RST_STACK;
      rd(CSR_OFF_STACK, m_sp, "stack reset");
      for (i = 0; i < 6; i++) rd(offs[i], 8'h00, "timer reset");
      rd(8'h55, CSR_READ_UNMAPPED, "unmapped read");
      for (i = 0; i < 2; i++) begin
         pulse(0);
         m_sp = m_sp + 8'h01;
         chk("push address", {8'h00, m_sp}, {8'h00, snap[7:0]});
      end
      // Two pushes on consecutive cycles
      @(posedge clk);
      ctl[0] <= 1'b1;
      repeat (2) @(posedge clk);
      ctl[0] <= 1'b0;
      m_sp = m_sp + 8'h02;
      rd(CSR_OFF_STACK, m_sp, "double push");
      m_sp = 8'($random(seed));
      wr(CSR_OFF_STACK, m_sp);
      pulse(0);
      chk("relocated push", {8'h00, m_sp + 8'h01}, {8'h00, snap[7:0]});
      pulse(1);
      rd(CSR_OFF_STACK, m_sp, "stack after pop");
      m_dp = 16'($random(seed));
      wr(CSR_OFF_DPH, m_dp[15:8]);
      wr(CSR_OFF_DPL, m_dp[7:0]);
      #1 chk("pointer pair", m_dp, data_pointer_pair);
      m_dp = {m_dp[7:0], 8'hFF};
      data_pointer_value <= m_dp;
      pulse(2);
      pulse(3);
      m_dp = m_dp + 16'h0001;
      rd(CSR_OFF_DPH, m_dp[15:8], "pointer high");
      rd(CSR_OFF_DPL, m_dp[7:0], "pointer low");
      v = 8'($random(seed));
      wr(CSR_OFF_SERIAL, v);
      #1 chk("transmit start", 16'h0001, {15'h0000, tx_start});
      chk("transmit byte", {8'h00, v}, {8'h00, tx_holding});
      rx_data <= ~v;
      pulse(6);
      rd(CSR_OFF_SERIAL, ~v, "receive byte");
      for (i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         v[4:3] = i[1:0];
         wr(CSR_OFF_STATUS, v);
         #1 chk("bank base", {8'h00, 3'b000, v[4:3], 3'b000}, {8'h00, bank_base_addr});
         acc_value <= 8'($random(seed));
         {alu_carry, alu_aux_carry, alu_overflow} <= 3'($random(seed));
         pulse(5);
         pulse(4);
         m_flags = {alu_carry, alu_aux_carry, v[5:3], alu_overflow, v[1], ^acc_value};
         rd(CSR_OFF_STATUS, m_flags, "status word");
      end
      // Software write of the accumulator must also refresh parity
      v = 8'($random(seed));
      wr(CSR_OFF_ACC, v);
      rd(CSR_OFF_ACC, v, "accumulator");
      m_flags[0] = ^v;
      rd(CSR_OFF_STATUS, m_flags, "parity after write");
      for (i = 0; i < 6; i++) begin
         v = 8'($random(seed));
         wr(offs[i], v);
         rd(offs[i], v, "timer byte");
      end
      wr(CSR_OFF_T0L, 8'hFF);
      wr(CSR_OFF_T0H, 8'hFF);
      pulse(7);
      chk("timer0 wrap", 16'h0001, {15'h0000, snap[8]});
      rd(CSR_OFF_T0H, 8'h00, "timer0 after wrap");
      wr(CSR_OFF_T1L, 8'hFF);
      wr(CSR_OFF_T1H, 8'hFF);
      timer1_tick <= 1'b1;
      #1 chk("timer1 wrap", 16'h0001, {15'h0000, timer1_overflow});
      @(posedge clk);
      timer1_tick <= 1'b0;
      rd(CSR_OFF_T1L, 8'h00, "timer1 after wrap");
      w = 16'($random(seed));
      wr(CSR_OFF_CAPH, w[15:8]);
      wr(CSR_OFF_CAPL, w[7:0]);
      wr(CSR_OFF_T2H, 8'hFF);
      wr(CSR_OFF_T2L, 8'hFF);
      wr(CSR_OFF_T2CTL, 8'h04);
      pulse(8);
      chk("timer2 wrap", 16'h0001, {15'h0000, snap[9]});
      wr(CSR_OFF_T2CTL, 8'h01);
      rd(CSR_OFF_T2H, w[15:8], "reload high");
      rd(CSR_OFF_T2L, w[7:0], "reload low");
      wr(CSR_OFF_T2H, w[7:0]);
      wr(CSR_OFF_T2L, w[15:8]);
      pulse(9);
      repeat (2) @(posedge clk);
      rd(CSR_OFF_CAPH, w[7:0], "capture high");
      rd(CSR_OFF_CAPL, w[15:8], "capture low");
      conclude();
   end
endmodule
